// >>> src/video_auto_size_measure.sv
// file: auto size timing measurement with apb register access and interrupt
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module video_auto_size_measure #(
   parameter int PORCH_W = auto_size_pkg::PORCH_WIDTH,
   parameter int SYNC_W = auto_size_pkg::SYNC_WIDTH,
   parameter int LOSS_CYCLES = auto_size_pkg::LOSS_TIMEOUT_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // video timing, synchronous to pclk, one pixel per enabled cycle
   input wire logic pixel_en,
   input wire logic hsync,
   input wire logic vsync,
   input wire logic video_active,
   output logic irq
);
   // ***********************************************
   // elaboration checks
   // ***********************************************
   initial begin
      if (PORCH_W != 11 || SYNC_W != 8) $error("porch must be 11 and sync 8 bits");
      if (LOSS_CYCLES < 2) $error("loss timeout too short");
   end

   // ***********************************************
   // sync edge detection
   // ***********************************************
   logic hsync_reg;  // previous horizontal sync level
   logic vsync_reg;  // previous vertical sync level
   logic active_reg; // previous video active level
   // no fall detector: hcount is held at zero through sync
   wire hs_rise = !hsync_reg && hsync;          // line start
   wire vs_rise = !vsync_reg && vsync;
   wire vs_fall = vsync_reg && !vsync;
   wire act_rise = !active_reg && video_active; // back porch ends
   wire act_fall = active_reg && !video_active; // front porch starts

   // edge history register
   // reset levels match idle pins: no false edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hsync_reg <= 1'b0;
         vsync_reg <= 1'b0;
         active_reg <= 1'b0;
      end else if (ce) begin
         hsync_reg <= hsync;
         vsync_reg <= vsync;
         active_reg <= video_active;
      end
   end

   // ***********************************************
   // duration counters
   // ***********************************************
   logic [PORCH_W-1:0] hcount; // pixels since horizontal sync end
   logic [PORCH_W-1:0] vcount; // lines since last vertical reference edge
   logic in_vbp_reg; // between vsync end and first active line
   logic in_vfp_reg; // from the first active line end until vsync
   logic line_active_reg; // active video seen during current line

   // pixels counted from the falling sync edge
   edge_counter #(.WIDTH(PORCH_W)) hcounter (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      // held in sync: first porch pixel counts
      .restart(hsync),
      .advance(pixel_en),
      .count(hcount)
   );

   // lines counted from each vertical edge, advanced by line start
   edge_counter #(.WIDTH(PORCH_W)) vcounter (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      // each active line end restarts; the last one wins
      .restart(vs_rise || vs_fall || (act_fall && !in_vbp_reg && line_active_reg)),
      .advance(hs_rise),
      .count(vcount)
   );

   // ***********************************************
   // measurement control
   // ***********************************************
   typedef enum logic [1:0] {IDLE, ARM, MEASURE} meas_state_t;
   meas_state_t state_reg;
   meas_state_t state_next;
   logic [1:0] field_cnt_reg;
   // presence: cycles since the last line start
   logic [31:0] quiet_reg;           // cycles since last horizontal edge
   logic video_present;
   logic enable_reg;                 // auto size enable, software set
   logic [PORCH_W-1:0] hbp_reg;
   logic [PORCH_W-1:0] vfp_reg;
   logic [SYNC_W-1:0] vsync_w_reg;
   logic [PORCH_W-1:0] vbp_reg;
   logic [PORCH_W-1:0] pvfp_reg;
   logic [SYNC_W-1:0] pvsync_reg;
   logic [PORCH_W-1:0] pvbp_reg;
   logic [auto_size_pkg::IRQ_WIDTH-1:0] irq_status_reg;
   logic [auto_size_pkg::IRQ_WIDTH-1:0] irq_mask_reg;
   logic vdreset_pend_reg;

   // ***********************************************
   // apb decode
   // ***********************************************
   // byte address from register index; paddr holds byte address
   function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction : hit

   wire apb_acc = psel && penable;
   wire apb_wr = apb_acc && pwrite;
   wire hit_ctrl = hit(paddr, auto_size_pkg::IDX_CTRL);
   wire hit_stat = hit(paddr, auto_size_pkg::IDX_IRQ_STATUS);
   wire hit_mask = hit(paddr, auto_size_pkg::IDX_IRQ_MASK);
   wire wr_ctrl = apb_wr && hit_ctrl;
   wire set_enable = wr_ctrl && pwdata[auto_size_pkg::CTRL_ENABLE_BIT] && !enable_reg;
   wire vd_reset = wr_ctrl && pwdata[auto_size_pkg::CTRL_VDRESET_BIT];
   wire wr_stat = apb_wr && hit_stat;
   wire wr_mask = apb_wr && hit_mask;

   // video presence: a horizontal edge seen within the loss timeout
   // limitation: very long lines read as lost
   assign video_present = (quiet_reg < LOSS_CYCLES);
   wire field_end = vs_rise && in_vfp_reg;
   wire meas_done = (state_reg == MEASURE) && field_end &&
                    (field_cnt_reg == 2'(auto_size_pkg::MEASURE_FIELDS - 1));

   // state transitions: arm waits for a clean field start, so every field is whole
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         IDLE: begin
            if (set_enable) state_next = ARM;
         end
         ARM: begin
            if (!video_present) state_next = IDLE;
            else if (vs_rise) state_next = MEASURE;
         end
         MEASURE: begin
            if (!video_present || meas_done) state_next = IDLE;
         end
         default: state_next = IDLE; // spare code
      endcase
   end

   // enable stays high while measuring and clears itself at the end
   // a start while busy is ignored
   wire enable_next = (state_next != IDLE);

   // state, field count and presence timer
   // the timer stops at the limit, never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= IDLE;
         field_cnt_reg <= 2'h0;
         quiet_reg <= 32'h0;
         enable_reg <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         enable_reg <= enable_next;
         quiet_reg <= (hs_rise) ? 32'h0 : (video_present ? quiet_reg + 32'h1 : quiet_reg);
         if (state_reg != MEASURE) field_cnt_reg <= 2'h0;
         else if (field_end) field_cnt_reg <= field_cnt_reg + 2'h1;
      end
   end

   // vertical phase tracking per line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_vbp_reg <= 1'b0;
         in_vfp_reg <= 1'b0;
         line_active_reg <= 1'b0;
      end else if (ce) begin
         if (hs_rise) line_active_reg <= 1'b0;
         else if (video_active) line_active_reg <= 1'b1;
         if (vs_fall) in_vbp_reg <= 1'b1;
         else if (act_rise) in_vbp_reg <= 1'b0;
         if (vs_rise) in_vfp_reg <= 1'b0;
         else if (act_fall && !in_vbp_reg) in_vfp_reg <= 1'b1;
      end
   end

   // ***********************************************
   // capture of current results
   // ***********************************************
   wire measuring = (state_reg == MEASURE);
   wire hbp_cap = measuring && act_rise;                 // pixels from sync end to video
   wire vbp_cap = measuring && in_vbp_reg && act_rise;   // lines from vsync end to video
   wire vfp_cap = measuring && in_vfp_reg && vs_rise;    // lines from last video to vsync
   wire vsw_cap = measuring && vs_fall;                  // lines inside vsync
   // long sync saturates at 8 bits
   logic [SYNC_W-1:0] vsync_lines;
   assign vsync_lines = (vcount > PORCH_W'({SYNC_W{1'b1}})) ? '1 : vcount[SYNC_W-1:0];

   // smallest porch values are kept, sync width takes the latest; first capture after arm loads directly
   // zero means none yet, so a zero porch is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hbp_reg <= '0;
         vfp_reg <= '0;
         vsync_w_reg <= '0;
         vbp_reg <= '0;
      end else if (ce) begin
         if (set_enable || !video_present) begin
            hbp_reg <= '0;
            vfp_reg <= '0;
            vsync_w_reg <= '0;
            vbp_reg <= '0;
         end else begin
            if (hbp_cap && (hbp_reg == '0 || hcount < hbp_reg)) hbp_reg <= hcount;
            if (vfp_cap && (vfp_reg == '0 || vcount < vfp_reg)) vfp_reg <= vcount;
            if (vsw_cap) vsync_w_reg <= vsync_lines;
            if (vbp_cap && (vbp_reg == '0 || vcount < vbp_reg)) vbp_reg <= vcount;
         end
      end
   end

   // ***********************************************
   // previous field copies
   // ***********************************************
   // at each field end the field's front porch count and the held sync width and back porch results move into the previous set;
   // a video detect reset holds them at zero until the next whole field
   // the field cut by the reset is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pvfp_reg <= '0;
         pvsync_reg <= '0;
         pvbp_reg <= '0;
         vdreset_pend_reg <= 1'b0;
      end else if (ce) begin
         if (vd_reset || !video_present) begin
            pvfp_reg <= '0;
            pvsync_reg <= '0;
            pvbp_reg <= '0;
            vdreset_pend_reg <= vd_reset;
         end else if (vs_rise && in_vfp_reg) begin
            if (vdreset_pend_reg) begin
               vdreset_pend_reg <= 1'b0; // partial field after reset is discarded
            end else begin
               pvfp_reg <= vcount;
               pvsync_reg <= vsync_w_reg;
               pvbp_reg <= vbp_reg;
            end
         end
      end
   end

   // ***********************************************
   // interrupt status and mask
   // ***********************************************
   logic [auto_size_pkg::IRQ_WIDTH-1:0] irq_event;
   assign irq_event[auto_size_pkg::IRQ_DONE_BIT] = enable_reg && !enable_next;
   assign irq_event[auto_size_pkg::IRQ_NOVIDEO_BIT] = (quiet_reg == 32'(LOSS_CYCLES - 1));
   logic [auto_size_pkg::IRQ_WIDTH-1:0] clear_bits;
   assign clear_bits = wr_stat ? pwdata[auto_size_pkg::IRQ_WIDTH-1:0] : '0;

   // set wins over write-one-to-clear
   // an event in the clear cycle is kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= '0;
         irq_mask_reg <= auto_size_pkg::IRQ_MASK_RESET;
      end else if (ce) begin
         irq_status_reg <= (irq_status_reg & ~clear_bits) | irq_event;
         if (wr_mask) irq_mask_reg <= pwdata[auto_size_pkg::IRQ_WIDTH-1:0];
      end
   end
   assign irq = |(irq_status_reg & irq_mask_reg);

   // ***********************************************
   // apb read path
   // ***********************************************
   logic [31:0] rdata_mux;
   logic addr_ok;
   // results read only when enable has cleared; earlier reads see live values
   always_comb begin
      rdata_mux = 32'h0;
      addr_ok = 1'b1;
      unique case (paddr)
         {auto_size_pkg::IDX_VFP_LOW, 2'b00}: rdata_mux = {24'h0, vfp_reg[7:0]};
         {auto_size_pkg::IDX_VFP_HIGH, 2'b00}: rdata_mux = {29'h0, vfp_reg[10:8]};
         {auto_size_pkg::IDX_VSYNC, 2'b00}: rdata_mux = {24'h0, vsync_w_reg};
         {auto_size_pkg::IDX_VBP_LOW, 2'b00}: rdata_mux = {24'h0, vbp_reg[7:0]};
         {auto_size_pkg::IDX_VBP_HIGH, 2'b00}: rdata_mux = {29'h0, vbp_reg[10:8]};
         {auto_size_pkg::IDX_PVFP_LOW, 2'b00}: rdata_mux = {24'h0, pvfp_reg[7:0]};
         {auto_size_pkg::IDX_PVFP_HIGH, 2'b00}: rdata_mux = {29'h0, pvfp_reg[10:8]};
         {auto_size_pkg::IDX_PVSYNC, 2'b00}: rdata_mux = {24'h0, pvsync_reg};
         {auto_size_pkg::IDX_PVBP_LOW, 2'b00}: rdata_mux = {24'h0, pvbp_reg[7:0]};
         {auto_size_pkg::IDX_PVBP_HIGH, 2'b00}: rdata_mux = {29'h0, pvbp_reg[10:8]};
         {auto_size_pkg::IDX_HBP, 2'b00}: rdata_mux = {21'h0, hbp_reg};
         {auto_size_pkg::IDX_CTRL, 2'b00}: rdata_mux = {31'h0, enable_reg};
         {auto_size_pkg::IDX_IRQ_STATUS, 2'b00}: rdata_mux = {30'h0, irq_status_reg};
         {auto_size_pkg::IDX_IRQ_MASK, 2'b00}: rdata_mux = {30'h0, irq_mask_reg};
         default: addr_ok = 1'b0;
      endcase
   end

   // read data registered in the setup cycle, presented in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (ce && psel && !penable) begin
         prdata <= rdata_mux;
      end
   end

   // zero wait state; unmapped addresses answer with an error
   // unaligned addresses are refused as well
   assign pready = 1'b1;
   assign pslverr = apb_acc && !addr_ok;
endmodule : video_auto_size_measure
`default_nettype wire

// >>> src/auto_size_pkg.sv
// package: register map, field layout and timing constants of the auto size measurement block
package auto_size_pkg;
   // ***********************************************
   // register indices (printed offsets are not word aligned; byte address = 4 * index)
   // ***********************************************
   localparam logic [15:0] IDX_VFP_LOW = 16'h8586;
   localparam logic [15:0] IDX_VFP_HIGH = 16'h8587;
   localparam logic [15:0] IDX_VSYNC = 16'h8588;
   localparam logic [15:0] IDX_VBP_LOW = 16'h8589;
   localparam logic [15:0] IDX_VBP_HIGH = 16'h858a;
   localparam logic [15:0] IDX_PVFP_LOW = 16'h858b;
   localparam logic [15:0] IDX_PVFP_HIGH = 16'h858c;
   localparam logic [15:0] IDX_PVSYNC = 16'h858d;
   localparam logic [15:0] IDX_PVBP_LOW = 16'h858e;
   localparam logic [15:0] IDX_PVBP_HIGH = 16'h858f;
   // registers of our own placement
   localparam logic [15:0] IDX_HBP = 16'h8584;
   localparam logic [15:0] IDX_CTRL = 16'h85a0;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h85a1;
   localparam logic [15:0] IDX_IRQ_MASK = 16'h85a2;
   // ***********************************************
   // control and interrupt fields
   // ***********************************************
   localparam int CTRL_ENABLE_BIT = 0;  // auto size enable, self clearing
   localparam int CTRL_VDRESET_BIT = 1; // video detect reset, write one pulse
   localparam int IRQ_DONE_BIT = 0;     // measurement finished
   localparam int IRQ_NOVIDEO_BIT = 1;  // video lost
   localparam int IRQ_WIDTH = 2;
   localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 2'h0;
   // ***********************************************
   // widths and timing
   // ***********************************************
   localparam int PORCH_WIDTH = 11;
   localparam int SYNC_WIDTH = 8;
   localparam int MEASURE_FIELDS = 2;     // fields watched per measurement
   localparam int CLK_MHZ = 10;
   localparam int LOSS_TIMEOUT_US = 100;  // no line edge this long means no video
   localparam int LOSS_TIMEOUT_CYCLES = LOSS_TIMEOUT_US * CLK_MHZ;
endpackage : auto_size_pkg

// >>> src/edge_counter.sv
// file: saturating duration counter restarted on a strobe
`timescale 1ns/100ps
`default_nettype none
module edge_counter #(
   parameter int WIDTH = 11
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic restart,   // start a new count from zero
   input wire logic advance,   // one unit of time elapsed
   output logic [WIDTH-1:0] count
);
   initial begin
      if (WIDTH < 2 || WIDTH > 16) $error("edge_counter width out of range");
   end
   logic [WIDTH-1:0] count_next;
   wire saturated = &count;
   // saturation keeps a stuck signal from wrapping into a plausible small value
   assign count_next = restart ? '0 : (advance && !saturated) ? count + 1'b1 : count;
   // counter register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (ce) begin
         count <= count_next;
      end
   end
endmodule : edge_counter
`default_nettype wire

// >>> verif/video_auto_size_measure_chk.sv
// checker of the auto size block's bus and result ports
`timescale 1ns/100ps
`default_nettype none
module video_auto_size_measure_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pixel_en,
   input wire logic hsync,
   input wire logic vsync,
   input wire logic video_active,
   input wire logic irq
);
   // ****
   // request decode
   // ****
   wire [15:0] idx = paddr[17:2]; // word index
   wire acc = psel && penable && ce; // access that takes effect
   wire rd = acc && !pwrite; // read access
   wire wr = acc && pwrite; // write access
   wire ctl = idx == auto_size_pkg::IDX_CTRL; // control word
   wire vcur = idx >= auto_size_pkg::IDX_VFP_LOW && idx <= auto_size_pkg::IDX_VBP_HIGH;
   wire cur = vcur || idx == auto_size_pkg::IDX_HBP; // current results
   wire prior = idx >= auto_size_pkg::IDX_PVFP_LOW && idx <= auto_size_pkg::IDX_PVBP_HIGH;
   wire ctlw = idx >= auto_size_pkg::IDX_CTRL && idx <= auto_size_pkg::IDX_IRQ_MASK;
   wire mapped = cur || prior || ctlw; // any register
   // upper parts of 11-bit values, and the sync widths
   wire hi = idx == auto_size_pkg::IDX_VFP_HIGH || idx == auto_size_pkg::IDX_VBP_HIGH ||
      idx == auto_size_pkg::IDX_PVFP_HIGH || idx == auto_size_pkg::IDX_PVBP_HIGH;
   wire sw = idx == auto_size_pkg::IDX_VSYNC || idx == auto_size_pkg::IDX_PVSYNC;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ****
   // properties
   // ****
   sequence s_start; // enable set by software
      wr && ctl && pwdata[auto_size_pkg::CTRL_ENABLE_BIT];
   endsequence
   sequence s_vdrst; // video detect reset written
      wr && ctl && pwdata[auto_size_pkg::CTRL_VDRESET_BIT];
   endsequence
   a_ready_high: assert property (psel |-> pready)
      else $error("pready low in a transfer");
   a_err_unmapped: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_err_mapped: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access refused");
   // read data may only move at the edge that closes a setup cycle
   a_rdata_hold: assert property (!$past(psel && !penable) |-> $stable(prdata))
      else $error("read data moved outside setup");
   a_hbp_width: assert property (rd && idx == auto_size_pkg::IDX_HBP |-> prdata[31:11] == 21'h0)
      else $error("horizontal porch wider than 11 bits");
   a_sync_width: assert property (rd && sw |-> prdata[31:8] == 24'h0)
      else $error("sync width wider than 8 bits");
   a_high_width: assert property (rd && hi |-> prdata[31:3] == 29'h0)
      else $error("upper porch part wider than 3 bits");
   a_start_busy: assert property (s_start ##[2:3] (rd && ctl) |-> prdata[0])
      else $error("enable not seen after start");
   a_start_clear: assert property (s_start ##[2:3] (rd && cur) |-> prdata == 32'h0)
      else $error("result not back to default after start");
   a_vdrst_zero: assert property (s_vdrst ##[2:3] (rd && prior) |-> prdata == 32'h0)
      else $error("previous field value not cleared");
   a_mask_quiet: assert property (wr && idx == auto_size_pkg::IDX_IRQ_MASK &&
      pwdata[1:0] == 2'h0 |=> !irq)
      else $error("irq high with everything masked");
endmodule : video_auto_size_measure_chk
bind video_auto_size_measure video_auto_size_measure_chk video_auto_size_measure_chk_inst (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pixel_en(pixel_en), .hsync(hsync), .vsync(vsync),
   .video_active(video_active), .irq(irq));
`default_nettype wire

// >>> verif/video_source_model.sv
// raster source model: sync pulses and active video window
`timescale 1ns/100ps
`default_nettype none
module video_source_model #(
   parameter int HS = 2, HB = 5, HA = 10, HF = 3,
   parameter int VS = 3, VB = 4, VA = 6, VF = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run, // low models a lost source
   output logic pixel_en,
   output logic hsync,
   output logic vsync,
   output logic video_active
);
   localparam int HT = HS + HB + HA + HF; // pixels per line
   localparam int VT = VS + VB + VA + VF; // lines per field
   int h_reg; // pixel in line
   int v_reg; // line in field
   // ****
   // raster
   // ****
   // counters freeze and every line drops when the source stops, so no stale sync remains
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         h_reg <= 0;
         v_reg <= 0;
         {pixel_en, hsync, vsync, video_active} <= 4'h0;
      end else begin
         if (run) begin
            h_reg <= (h_reg == HT - 1) ? 0 : h_reg + 1;
         end
         if (run && h_reg == HT - 1) begin
            v_reg <= (v_reg == VT - 1) ? 0 : v_reg + 1;
         end
         pixel_en <= run;
         hsync <= run && h_reg < HS;
         vsync <= run && v_reg < VS;
         video_active <= run && v_reg >= VS + VB && v_reg < VS + VB + VA &&
            h_reg >= HS + HB && h_reg < HS + HB + HA;
      end
   end
endmodule : video_source_model
`default_nettype wire

// >>> verif/test_video_auto_size_measure.sv
// self-checking testbench of the auto size measurement block
`timescale 1ns/100ps
`default_nettype none
module test_video_auto_size_measure;
   localparam int HB = 5, VS = 3, VB = 4, VF = 6; // raster of the source
   localparam int FIELD = 20 * (VS + VB + 6 + VF); // cycles per field
   logic pclk = 1'b0; // 10 MHz
   logic presetn, ce, psel, penable, pwrite, run, pready, pslverr, er;
   logic pixel_en, hsync, vsync, video_active, irq;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   int error_cnt = 0; // mismatches
   int samples_checked = 0; // comparisons
   always #50 pclk = ~pclk;
   // short loss timeout suits the short raster
   video_auto_size_measure #(.LOSS_CYCLES(50)) video_auto_size_measure_inst (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pixel_en(pixel_en), .hsync(hsync), .vsync(vsync),
      .video_active(video_active), .irq(irq));
   video_source_model #(.HB(HB), .VS(VS), .VB(VB), .VF(VF)) video_source_model_inst (
      .pclk(pclk), .presetn(presetn), .run(run), .pixel_en(pixel_en), .hsync(hsync),
      .vsync(vsync), .video_active(video_active));
   // ****
   // tasks
   // ****
   task automatic close_out();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // porch counts may differ by one with edge alignment
   task automatic near(input string nm, input logic [31:0] s, input int e);
      chk(nm, s, (s + 32'h1 >= 32'(e) && s <= 32'(e + 1)) ? s : 32'(e));
   endtask : near
   // one apb transfer; held until pready is sampled high
   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input string nm, input logic [15:0] idx, input logic [31:0] e);
      apb(1'b0, idx, 32'h0);
      chk(nm, rd, e);
   endtask : rdchk
   // 11-bit value from its low and high words
   task automatic rd11(input logic [15:0] lo);
      apb(1'b0, lo, 32'h0);
      v = rd;
      apb(1'b0, lo + 16'h1, 32'h0);
      v = v | (rd << 8);
   endtask : rd11
   // irq is looked at mid-cycle, after register updates settle
   task automatic irqchk(input logic e);
      @(negedge pclk);
      chk("irq", 32'(irq), 32'(e));
   endtask : irqchk
   // results are read only once enable has cleared
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         apb(1'b0, auto_size_pkg::IDX_CTRL, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 1000);
      chk("enable cleared", 32'(rd[0]), 32'h0);
   endtask : wait_done
   // ****
   // watchdog: the sequence needs well under 8000 cycles
   // ****
   initial begin
      repeat (30000) @(posedge pclk);
      error_cnt++;
      close_out();
   end
   // ****
   // tests
   // ****
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      run = 1'b0;
      paddr = 18'h0;
      pwdata = 32'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // every register reads zero out of reset with no video
      for (int i = 0; i < 15; i++) begin
         rdchk("reset value", i < 12 ? auto_size_pkg::IDX_HBP + 16'(i) :
            auto_size_pkg::IDX_CTRL + 16'(i - 12), 32'h0);
      end
      // unmapped index refused; result register ignores writes
      rdchk("unmapped data", auto_size_pkg::IDX_HBP + 16'h1, 32'h0);
      chk("unmapped error", 32'(er), 32'h1);
      apb(1'b1, auto_size_pkg::IDX_VFP_LOW, 32'h0000_00ff);
      rdchk("read only", auto_size_pkg::IDX_VFP_LOW, 32'h0);
      // a write with the clock enable low is lost
      ce <= 1'b0;
      apb(1'b1, auto_size_pkg::IDX_IRQ_MASK, 32'h3);
      ce <= 1'b1;
      rdchk("frozen mask", auto_size_pkg::IDX_IRQ_MASK, 32'h0);
      apb(1'b1, auto_size_pkg::IDX_IRQ_MASK, 32'h3);
      rdchk("mask", auto_size_pkg::IDX_IRQ_MASK, 32'h3);
      rdchk("idle loss", auto_size_pkg::IDX_IRQ_STATUS, 32'h2);
      // measurement on running video
      run <= 1'b1;
      repeat (FIELD) @(posedge pclk);
      apb(1'b1, auto_size_pkg::IDX_IRQ_STATUS, 32'h3); // drop stale loss flag
      apb(1'b1, auto_size_pkg::IDX_CTRL, 32'h1);
      rdchk("busy", auto_size_pkg::IDX_CTRL, 32'h1);
      wait_done();
      rdchk("horiz back porch", auto_size_pkg::IDX_HBP, 32'(HB));
      rd11(auto_size_pkg::IDX_VFP_LOW);
      near("front porch", v, VF);
      apb(1'b0, auto_size_pkg::IDX_VSYNC, 32'h0);
      near("sync width", rd, VS);
      rd11(auto_size_pkg::IDX_VBP_LOW);
      near("back porch", v, VB);
      rd11(auto_size_pkg::IDX_PVFP_LOW);
      near("prior front porch", v, VF);
      apb(1'b0, auto_size_pkg::IDX_PVSYNC, 32'h0);
      near("prior sync", rd, VS);
      rd11(auto_size_pkg::IDX_PVBP_LOW);
      near("prior back porch", v, VB);
      irqchk(1'b1);
      rdchk("status done", auto_size_pkg::IDX_IRQ_STATUS, 32'h1);
      apb(1'b1, auto_size_pkg::IDX_IRQ_STATUS, 32'h1);
      irqchk(1'b0);
      rdchk("status cleared", auto_size_pkg::IDX_IRQ_STATUS, 32'h0);
      // restart returns results to defaults; done stays masked
      apb(1'b1, auto_size_pkg::IDX_CTRL, 32'h1);
      rdchk("restart default", auto_size_pkg::IDX_VFP_LOW, 32'h0);
      apb(1'b1, auto_size_pkg::IDX_IRQ_MASK, 32'h0);
      wait_done();
      irqchk(1'b0);
      rdchk("masked status", auto_size_pkg::IDX_IRQ_STATUS, 32'h1);
      // video detect reset, then a wait of over two fields
      apb(1'b1, auto_size_pkg::IDX_CTRL, 32'h2);
      rdchk("prior cleared", auto_size_pkg::IDX_PVFP_LOW, 32'h0);
      repeat (2 * FIELD + 40) @(posedge pclk);
      rd11(auto_size_pkg::IDX_PVFP_LOW);
      near("prior refilled", v, VF);
      // losing the source zeroes results and raises the loss event
      apb(1'b1, auto_size_pkg::IDX_IRQ_MASK, 32'h3);
      apb(1'b1, auto_size_pkg::IDX_IRQ_STATUS, 32'h3);
      run <= 1'b0;
      repeat (100) @(posedge pclk);
      rd11(auto_size_pkg::IDX_VFP_LOW);
      chk("lost front porch", v, 32'h0);
      rd11(auto_size_pkg::IDX_PVFP_LOW);
      chk("lost prior porch", v, 32'h0);
      rdchk("lost status", auto_size_pkg::IDX_IRQ_STATUS, 32'h2);
      irqchk(1'b1);
      close_out();
   end
endmodule : test_video_auto_size_measure
`default_nettype wire
